/* File: tb/chain_diag_chk.sv */
// assertions on the ports of the chain diagnostic request block
`timescale 1ns/10ps
`default_nettype none
`include "chain_diag_params.svh"

module chain_diag_chk #(
    parameter int                  DATA_W         = `DEV_DATA_W,
    parameter logic [`TIMER_W-1:0] POWERUP_CYCLES = 20
) (
    input wire logic                                  CORE_CLK,
    input wire logic                                  RESET,
    input wire logic [`CHAIN_W-1:0]                   CHAIN_SEL,
    input wire logic [`DEV_W-1:0]                     DEVICE_SEL,
    input wire logic [`REQ_W-1:0]                     READ_REQUEST,
    input wire logic                                  SCAN_DONE,
    input wire logic [`COUNT_W-1:0]                   SCAN_COUNT,
    input wire chain_diag_pkg::list_t                 SCAN_TYPES,
    input wire logic [DATA_W-1:0]                     SCAN_DATA,
    input wire logic                                  LIVE_VALID,
    input wire chain_diag_pkg::chain_obs_t            LIVE,
    input wire logic                                  CHAIN_AUTO_LEARN,
    input wire logic [`NUM_CHAINS-1:0][`COUNT_W-1:0]  CFG_COUNT,
    input wire chain_diag_pkg::list_t [`NUM_CHAINS-1:0] CFG_TYPES,
    input wire logic [`REQ_W-1:0]                     READ_ACK,
    input wire logic [DATA_W-1:0]                     DEVICE_DATA,
    input wire chain_diag_pkg::list_t                 DEVICE_LIST,
    input wire logic                                  SCAN_START,
    input wire chain_diag_pkg::scan_req_t             SCAN_REQ,
    input wire chain_diag_pkg::status_t               STATUS,
    input wire logic                                  DATA_READY
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    sequence done_code(logic [7:0] c);
        SCAN_DONE && SCAN_REQ.code == c;
    endsequence
    // selection held and no fresh observation while status catches up
    sequence sel_quiet;
        (!LIVE_VALID && $stable(CHAIN_SEL)) ##1 $stable(CHAIN_SEL);
    endsequence

    start_pulse_a: assert property (SCAN_START |=> !SCAN_START)
        else $error("scan start longer than one cycle");
    ready_gate_a: assert property (!DATA_READY |=> !SCAN_START)
        else $error("scan started during hold-off");
    holdoff_pend_a: assert property (!DATA_READY |-> STATUS.pending)
        else $error("pending low during hold-off");
    start_code_a: assert property (
        SCAN_START |-> SCAN_REQ.code inside {8'h01, 8'h02, 8'h04})
        else $error("scan started with unknown code");
    rebase_ack_a: assert property (
        done_code(8'h02) |=> READ_ACK == 8'h02 &&
            DEVICE_LIST == $past(SCAN_TYPES))
        else $error("rebase completion wrong");
    list_ack_a: assert property (
        done_code(8'h04) |=> READ_ACK == 8'h04 &&
            DEVICE_LIST == $past(SCAN_TYPES))
        else $error("list completion wrong");
    single_ack_a: assert property (
        done_code(8'h01) |=> READ_ACK == 8'h01 &&
            DEVICE_DATA == $past(SCAN_DATA))
        else $error("single read completion wrong");
    flags_mirror_a: assert property (
        LIVE_VALID && DATA_READY && {1'b0, LIVE.idx} + 4'h1 == CHAIN_SEL
            ##1 sel_quiet
        |-> {STATUS[10:3], STATUS[0]} == $past(LIVE.flags, 2))
        else $error("status flags do not follow chain");
    count_clear_a: assert property (
        done_code(8'h04) ##0
            (!LIVE_VALID && {1'b0, SCAN_REQ.idx} + 4'h1 == CHAIN_SEL)
            ##1 sel_quiet |-> !STATUS.count_change)
        else $error("count change not cleared by list request");
endmodule // chain_diag_chk
`default_nettype wire

/* File: tb/chain_diag_request_status_tb.sv */
// self-checking bench for the chain diagnostic request and status block
`timescale 1ns/10ps
`default_nettype none
`include "chain_diag_params.svh"

module chain_diag_request_status_tb;
    localparam logic [31:0] HOLD = 32'h14; // short power-up hold-off
    logic                       clk = 0, rst = 1, lv = 0, learn = 0;
    logic [3:0]                 csel = 4'h1, dly = 4'h1;
    logic [5:0]                 dsel = 6'h01, scnt, cap_c;
    logic [7:0]                 req = 8'h00, ack;
    logic                       sdone, sstart, rdy;
    logic [63:0]                sdata, ddata, cap_d;
    chain_diag_pkg::list_t      stypes, dlist, cap_t;
    chain_diag_pkg::chain_obs_t live = '0;
    chain_diag_pkg::scan_req_t  sreq;
    chain_diag_pkg::status_t    status;
    logic [`NUM_CHAINS-1:0][`COUNT_W-1:0] cfg_cnt = '0;
    chain_diag_pkg::list_t [`NUM_CHAINS-1:0] cfg_typ = '0;
    int n_mismatch = 0, n_compared = 0, cyc = 0, starts = 0;
    int bcnt [8];
    chain_diag_pkg::list_t btyp [8];
    bit seen [8], cc [8], ch [8];

    chain_diag_request_status #(.POWERUP_CYCLES(HOLD)) DUT (
        .CORE_CLK(clk), .RESET(rst), .CHAIN_SEL(csel), .DEVICE_SEL(dsel),
        .READ_REQUEST(req), .SCAN_DONE(sdone), .SCAN_COUNT(scnt),
        .SCAN_TYPES(stypes), .SCAN_DATA(sdata), .LIVE_VALID(lv),
        .LIVE(live), .CHAIN_AUTO_LEARN(learn), .CFG_COUNT(cfg_cnt),
        .CFG_TYPES(cfg_typ), .READ_ACK(ack), .DEVICE_DATA(ddata),
        .DEVICE_LIST(dlist), .SCAN_START(sstart), .SCAN_REQ(sreq),
        .STATUS(status), .DATA_READY(rdy));
    scan_responder far_end (.clk(clk), .rst(rst), .start(sstart),
        .delay(dly), .done(sdone), .count(scnt), .types(stypes),
        .data(sdata));

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (sstart) starts++;
        if (sdone) begin
            cap_c = scnt;
            cap_t = stypes;
            cap_d = sdata;
        end
        if (cyc == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic obs(input int i, input logic [5:0] c,
                       input chain_diag_pkg::list_t t);
        chain_diag_pkg::chain_flags_t f;
        f = 9'($urandom);
        csel = 4'(i + 1);
        live = '{idx: 3'(i), count: c, types: t, flags: f};
        lv = 1;
        @(negedge clk);
        lv = 0;
        if (seen[i] && c != bcnt[i]) cc[i] = 1;
        if (seen[i] && learn && (c != bcnt[i] || t != btyp[i])) ch[i] = 1;
        if (!seen[i]) begin
            seen[i] = 1;
            bcnt[i] = c;
            btyp[i] = t;
        end
        repeat (2) @(negedge clk);
        chk(status.count_change, cc[i]);
        chk(status.chain_change, ch[i]);
        chk(status.count_alert, !learn && c != cfg_cnt[i]);
        chk(status.order_alert, !learn && t != cfg_typ[i]);
        chk({status[10:3], status[0]}, f);
    endtask

    task automatic rq(input logic [7:0] code, input int c,
                      input logic [5:0] d);
        int n;
        n = 0;
        dly = 4'($urandom_range(5));
        csel = 4'(c);
        dsel = d;
        req = code;
        while (ack !== code && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk(ack, code);
        chk(sreq, {code, 3'(c - 1), d});
        if (code == 8'h01) chk(ddata, cap_d);
        else chk(dlist, cap_t);
        if (code == 8'h02) begin
            bcnt[c - 1] = cap_c;
            btyp[c - 1] = cap_t;
            seen[c - 1] = 1;
            ch[c - 1] = 0;
        end
        if (code == 8'h04) cc[c - 1] = 0;
        repeat (2) @(negedge clk);
        chk(status.count_change, cc[c - 1]);
        chk(status.chain_change, ch[c - 1]);
        req = 8'h00;
        repeat (2) @(negedge clk);
        chk(ack, 8'h00);
    endtask

    // refused request: no scan started, acknowledge untouched
    task automatic rf(input logic [7:0] code, input int c,
                      input logic [5:0] d);
        int s;
        s = starts;
        csel = 4'(c);
        dsel = d;
        req = code;
        repeat (8) @(negedge clk);
        chk(starts, s);
        chk(ack, 8'h00);
        req = 8'h00;
        repeat (2) @(negedge clk);
    endtask

    initial begin
        void'($urandom(32'h9e60));
        for (int i = 0; i < 8; i++) begin
            cfg_cnt[i] = 6'($urandom_range(31));
            cfg_typ[i] = {8{$urandom}};
        end
        repeat (6) @(negedge clk);
        rst = 0;
        chk(status.pending, 1'b1);
        chk(ack, 8'h00);
        // a request during hold-off must not start a scan
        req = 8'h02;
        while (rdy !== 1'b1 && cyc < 100) @(negedge clk);
        req = 8'h00;
        chk(rdy, 1'b1);
        chk(starts, 0);
        obs(0, cfg_cnt[0], cfg_typ[0]);
        obs(0, cfg_cnt[0] + 6'h01, cfg_typ[0]);
        rq(8'h04, 1, 6'h01);
        obs(0, cfg_cnt[0] + 6'h01, cfg_typ[0]);
        rq(8'h02, 1, 6'h01);
        obs(0, cap_c, cap_t);
        learn = 1;
        obs(0, cap_c, ~cap_t);
        rq(8'h02, 1, 6'h01);
        rq(8'h01, 2, 6'h20);
        rq(8'h01, 1, 6'h01);
        rq(8'h04, 8, 6'h05);
        rf(8'h03, 1, 6'h01);
        rf(8'hff, 1, 6'h01);
        rf(8'h01, 3, 6'h01);
        rf(8'h01, 1, 6'h00);
        rf(8'h01, 1, 6'h21);
        rf(8'h02, 9, 6'h01);
        stop_test();
    end
endmodule // chain_diag_request_status_tb

bind chain_diag_request_status chain_diag_chk #(.DATA_W(DATA_W),
    .POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (.CORE_CLK(CORE_CLK),
    .RESET(RESET), .CHAIN_SEL(CHAIN_SEL), .DEVICE_SEL(DEVICE_SEL),
    .READ_REQUEST(READ_REQUEST), .SCAN_DONE(SCAN_DONE),
    .SCAN_COUNT(SCAN_COUNT), .SCAN_TYPES(SCAN_TYPES),
    .SCAN_DATA(SCAN_DATA), .LIVE_VALID(LIVE_VALID), .LIVE(LIVE),
    .CHAIN_AUTO_LEARN(CHAIN_AUTO_LEARN), .CFG_COUNT(CFG_COUNT),
    .CFG_TYPES(CFG_TYPES), .READ_ACK(READ_ACK),
    .DEVICE_DATA(DEVICE_DATA), .DEVICE_LIST(DEVICE_LIST),
    .SCAN_START(SCAN_START), .SCAN_REQ(SCAN_REQ), .STATUS(STATUS),
    .DATA_READY(DATA_READY));
`default_nettype wire

/* File: tb/scan_responder.sv */
// behavioural chain receiver answering scan requests
`timescale 1ns/10ps
`default_nettype none
`include "chain_diag_params.svh"

module scan_responder (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic [3:0]       delay,
    output logic                  done,
    output logic [5:0]            count,
    output chain_diag_pkg::list_t types,
    output logic [63:0]           data
);
    int wait_n;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            wait_n <= -1;
            count <= 6'h15;
            types <= '1;
            data <= '0;
        end else begin
            // stale result lines toggle so nothing can lean on them
            done <= 1'b0;
            count <= ~count;
            types <= ~types;
            data <= ~data;
            if (start) begin
                wait_n <= int'(delay);
            end else if (wait_n == 0) begin
                done <= 1'b1;
                count <= 6'($urandom_range(32));
                types <= {8{$urandom}};
                data <= {$urandom, $urandom};
                wait_n <= -1;
            end else if (wait_n > 0) begin
                wait_n <= wait_n - 1;
            end
        end
    end
endmodule // scan_responder
`default_nettype wire

/* File: verilog/chain_diag_params.svh */
// constants for the chain diagnostic request and status block
`ifndef CHAIN_DIAG_PARAMS_SVH
`define CHAIN_DIAG_PARAMS_SVH

// read request codes and acknowledge values
`define REQ_W            8
`define REQ_IDLE         8'h00
`define REQ_SINGLE       8'h01
`define REQ_REBASE       8'h02
`define REQ_LIST         8'h04

// chain and device selection
`define CHAIN_W          4
`define CHAIN_IDX_W      3
`define NUM_CHAINS       8
`define CHAIN_MIN        4'h1
`define CHAIN_MAX_SINGLE 4'h2
`define CHAIN_MAX_LIST   4'h8
`define DEV_W            6
`define DEV_MIN          6'h01
`define DEV_MAX          6'h20
`define COUNT_W          6

// list block: one type byte per chain position
`define LIST_BYTES       32
`define LIST_W           (8 * `LIST_BYTES)

// per-device data width
`define DEV_DATA_W       64

// power-up hold-off of chain data
`define CLK_HZ           200000000
`define POWERUP_S        10
`define TIMER_W          32
`define POWERUP_CYCLES   (64'd`POWERUP_S * 64'd`CLK_HZ)

`endif

/* File: verilog/chain_diag_pkg.sv */
// types shared by the chain diagnostic request and status block
`include "chain_diag_params.svh"

package chain_diag_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } fsm_t;

    typedef logic [`LIST_W-1:0] list_t;

    // per-chain flags reported by the chain receiver
    typedef struct packed {
        logic pending;
        logic bad_type;
        logic unconfigured;
        logic term_missing;
        logic not_taught;
        logic wrong_actuator;
        logic internal_err;
        logic output_fault;
        logic switched_safety_output;
    } chain_flags_t;

    // one live observation of a chain
    typedef struct packed {
        logic [`CHAIN_IDX_W-1:0] idx;
        logic [`COUNT_W-1:0]     count;
        list_t                   types;
        chain_flags_t            flags;
    } chain_obs_t;

    // request handed to the chain receiver
    typedef struct packed {
        logic [`REQ_W-1:0]       code;
        logic [`CHAIN_IDX_W-1:0] idx;
        logic [`DEV_W-1:0]       device;
    } scan_req_t;

    // chain system status word
    typedef struct packed {
        logic count_alert;
        logic order_alert;
        logic pending;
        logic bad_type;
        logic unconfigured;
        logic term_missing;
        logic not_taught;
        logic wrong_actuator;
        logic internal_err;
        logic output_fault;
        logic chain_change;
        logic count_change;
        logic switched_safety_output;
    } status_t;

endpackage

/* File: verilog/chain_diag_request_status.sv */
// chain diagnostic request handler and chain system status word
`timescale 1ns/10ps
`default_nettype none
`include "chain_diag_params.svh"

module chain_diag_request_status #(
    parameter int                  DATA_W         = `DEV_DATA_W,
    parameter logic [`TIMER_W-1:0] POWERUP_CYCLES =
        `TIMER_W'(`POWERUP_CYCLES)
) (
    input  wire logic                           CORE_CLK,
    input  wire logic                           RESET,
    input  wire logic [`CHAIN_W-1:0]            CHAIN_SEL,
    input  wire logic [`DEV_W-1:0]              DEVICE_SEL,
    input  wire logic [`REQ_W-1:0]              READ_REQUEST,
    input  wire logic                           SCAN_DONE,
    input  wire logic [`COUNT_W-1:0]            SCAN_COUNT,
    input  wire chain_diag_pkg::list_t          SCAN_TYPES,
    input  wire logic [DATA_W-1:0]              SCAN_DATA,
    input  wire logic                           LIVE_VALID,
    input  wire chain_diag_pkg::chain_obs_t     LIVE,
    input  wire logic                           CHAIN_AUTO_LEARN,
    input  wire logic [`NUM_CHAINS-1:0][`COUNT_W-1:0] CFG_COUNT,
    input  wire chain_diag_pkg::list_t [`NUM_CHAINS-1:0] CFG_TYPES,
    output logic [`REQ_W-1:0]                   READ_ACK,
    output logic [DATA_W-1:0]                   DEVICE_DATA,
    output chain_diag_pkg::list_t               DEVICE_LIST,
    output logic                                SCAN_START,
    output chain_diag_pkg::scan_req_t           SCAN_REQ,
    output chain_diag_pkg::status_t             STATUS,
    output logic                                DATA_READY
);

    typedef struct packed {
        chain_diag_pkg::fsm_t                       fsm;
        logic [`REQ_W-1:0]                          last_req;
        chain_diag_pkg::scan_req_t                  req;
        logic                                       scan_start;
        logic [`REQ_W-1:0]                          ack;
        logic [DATA_W-1:0]                          dev_data;
        chain_diag_pkg::list_t                      list;
        logic [`NUM_CHAINS-1:0][`COUNT_W-1:0]       base_count;
        chain_diag_pkg::list_t [`NUM_CHAINS-1:0]    base_types;
        logic [`NUM_CHAINS-1:0]                     base_valid;
        logic [`NUM_CHAINS-1:0]                     count_change;
        logic [`NUM_CHAINS-1:0]                     chain_change;
        logic [`NUM_CHAINS-1:0]                     count_alert;
        logic [`NUM_CHAINS-1:0]                     order_alert;
        chain_diag_pkg::chain_flags_t [`NUM_CHAINS-1:0] flags;
        chain_diag_pkg::status_t                    status;
        logic                                       ready;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic   holdoff_done;

    // chain number within 1..max
    function automatic logic chain_ok(input logic [`CHAIN_W-1:0] sel,
                                      input logic [`CHAIN_W-1:0] max);
        return (sel >= `CHAIN_MIN) && (sel <= max);
    endfunction

    // chain number 1..8 to storage index 0..7
    function automatic logic [`CHAIN_IDX_W-1:0] chain_idx(
        input logic [`CHAIN_W-1:0] sel);
        logic [`CHAIN_W-1:0] d;
        d = sel - `CHAIN_MIN;
        return d[`CHAIN_IDX_W-1:0];
    endfunction

    powerup_holdoff #(
        .CYCLES (POWERUP_CYCLES)
    ) u_holdoff (
        .clk    (CORE_CLK),
        .rst    (RESET),
        .done   (holdoff_done)
    );

    always_comb begin
        logic [`CHAIN_IDX_W-1:0] i;
        logic [`CHAIN_IDX_W-1:0] c;
        logic                    start;
        i = '0;
        c = '0;
        start = 1'b0;
        s_next = s_reg;
        s_next.scan_start = 1'b0;
        s_next.ready = holdoff_done;

        case (s_reg.fsm)
            chain_diag_pkg::ST_IDLE: begin
                // requests wait for the hold-off so no stale data is served
                if (s_reg.ready && READ_REQUEST != s_reg.last_req) begin
                    s_next.last_req = READ_REQUEST;
                    case (READ_REQUEST)
                        `REQ_IDLE: begin
                            s_next.ack = `REQ_IDLE;
                        end
                        `REQ_SINGLE: begin
                            // only a 0 to 1 change starts a read
                            if (s_reg.last_req == `REQ_IDLE &&
                                chain_ok(CHAIN_SEL, `CHAIN_MAX_SINGLE) &&
                                DEVICE_SEL >= `DEV_MIN &&
                                DEVICE_SEL <= `DEV_MAX) begin
                                start = 1'b1;
                            end
                        end
                        `REQ_REBASE, `REQ_LIST: begin
                            if (chain_ok(CHAIN_SEL, `CHAIN_MAX_LIST)) begin
                                start = 1'b1;
                            end
                        end
                        default: begin
                            // unknown codes touch nothing but last_req
                        end
                    endcase
                    if (start) begin
                        s_next.req.code   = READ_REQUEST;
                        s_next.req.idx    = chain_idx(CHAIN_SEL);
                        s_next.req.device = DEVICE_SEL;
                        s_next.scan_start = 1'b1;
                        s_next.fsm        = chain_diag_pkg::ST_WAIT;
                    end
                end
            end
            chain_diag_pkg::ST_WAIT: begin
                if (SCAN_DONE) begin
                    i = s_reg.req.idx;
                    case (s_reg.req.code)
                        `REQ_SINGLE: begin
                            s_next.dev_data = SCAN_DATA;
                            s_next.ack = `REQ_SINGLE;
                        end
                        `REQ_REBASE: begin
                            s_next.list = SCAN_TYPES;
                            s_next.base_count[i] = SCAN_COUNT;
                            s_next.base_types[i] = SCAN_TYPES;
                            s_next.base_valid[i] = 1'b1;
                            s_next.chain_change[i] = 1'b0;
                            s_next.ack = `REQ_REBASE;
                        end
                        `REQ_LIST: begin
                            // baseline left as it was
                            s_next.list = SCAN_TYPES;
                            s_next.count_change[i] = 1'b0;
                            s_next.ack = `REQ_LIST;
                        end
                        default: begin
                            s_next.ack = s_reg.ack;
                        end
                    endcase
                    s_next.fsm = chain_diag_pkg::ST_IDLE;
                end
            end
            default: begin
                s_next.fsm = chain_diag_pkg::ST_IDLE;
            end
        endcase

        // live updates come after the clears so a set in the same cycle wins
        if (LIVE_VALID) begin
            i = LIVE.idx;
            s_next.flags[i] = LIVE.flags;
            if (!s_next.base_valid[i]) begin
                // first sight of a chain becomes its baseline
                s_next.base_count[i] = LIVE.count;
                s_next.base_types[i] = LIVE.types;
                s_next.base_valid[i] = 1'b1;
            end else begin
                // against the baseline as it will stand, so a
                // re-baseline in the same cycle is honoured
                if (LIVE.count != s_next.base_count[i]) begin
                    s_next.count_change[i] = 1'b1;
                end
                if (CHAIN_AUTO_LEARN &&
                    (LIVE.count != s_next.base_count[i] ||
                     LIVE.types != s_next.base_types[i])) begin
                    s_next.chain_change[i] = 1'b1;
                end
            end
            // configuration checks are meaningless while auto learning
            s_next.count_alert[i] = !CHAIN_AUTO_LEARN &&
                                    LIVE.count != CFG_COUNT[i];
            s_next.order_alert[i] = !CHAIN_AUTO_LEARN &&
                                    LIVE.types != CFG_TYPES[i];
        end

        // status word follows the selected chain, or chain 1 when CHAIN_SEL is outside 1..8
        if (chain_ok(CHAIN_SEL, `CHAIN_MAX_LIST)) begin
            c = chain_idx(CHAIN_SEL);
        end
        s_next.status.count_alert  = s_next.count_alert[c];
        s_next.status.order_alert  = s_next.order_alert[c];
        s_next.status.pending      = s_next.flags[c].pending ||
                                     !s_next.ready;
        s_next.status.bad_type     = s_next.flags[c].bad_type;
        s_next.status.unconfigured =
            s_next.flags[c].unconfigured;
        s_next.status.term_missing =
            s_next.flags[c].term_missing;
        s_next.status.not_taught   = s_next.flags[c].not_taught;
        s_next.status.wrong_actuator =
            s_next.flags[c].wrong_actuator;
        s_next.status.internal_err =
            s_next.flags[c].internal_err;
        // the 20 min switch-off countdown runs in the chain device
        s_next.status.output_fault =
            s_next.flags[c].output_fault;
        s_next.status.chain_change = s_next.chain_change[c];
        s_next.status.count_change = s_next.count_change[c];
        s_next.status.switched_safety_output =
            s_next.flags[c].switched_safety_output;
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            s_reg <= '0;
            s_reg.fsm <= chain_diag_pkg::ST_IDLE;
            s_reg.status.pending <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign READ_ACK    = s_reg.ack;
    assign DEVICE_DATA = s_reg.dev_data;
    assign DEVICE_LIST = s_reg.list;
    assign SCAN_START  = s_reg.scan_start;
    assign SCAN_REQ    = s_reg.req;
    assign STATUS      = s_reg.status;
    assign DATA_READY  = s_reg.ready;

endmodule // chain_diag_request_status

`default_nettype wire

/* File: verilog/powerup_holdoff.sv */
// power-up hold-off timer for chain diagnostic data
`timescale 1ns/10ps
`default_nettype none
`include "chain_diag_params.svh"

module powerup_holdoff #(
    parameter logic [`TIMER_W-1:0] CYCLES = `TIMER_W'(`POWERUP_CYCLES)
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      done
);

    typedef struct packed {
        logic [`TIMER_W-1:0] count;
        logic                done;
    } timer_state_t;

    timer_state_t s_reg;
    timer_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (!s_reg.done) begin
            if (s_reg.count >= CYCLES - `TIMER_W'(1)) begin
                s_next.done = 1'b1;
            end else begin
                s_next.count = s_reg.count + `TIMER_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done = s_reg.done;

endmodule // powerup_holdoff

`default_nettype wire
